// ---- common/isa_space_pkg.sv ----
/*
  package for the isa local space configuration block: register offsets,
  field positions, write masks, reset values, axi response codes and the carrier structs.
  assumes a single 40 mhz clock domain and an axi4-lite register port.
*/
package isa_space_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_MEM_RANGE = 6'h00;
  localparam logic [5:0] OFF_IO_RANGE = 6'h04;
  localparam logic [5:0] OFF_MEM_BASE = 6'h08;
  localparam logic [5:0] OFF_IO_BASE = 6'h0c;
  localparam logic [5:0] OFF_MEM_DESC = 6'h10;
  localparam logic [5:0] OFF_IO_DESC = 6'h14;
  localparam logic [5:0] OFF_MEM_SEL = 6'h18;
  localparam logic [5:0] OFF_IO_SEL = 6'h1c;
  localparam logic [5:0] OFF_STATUS = 6'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RANGE_LSB = 4;
  localparam int ENABLE_BIT = 0;
  localparam int READY_EN_BIT = 1;
  localparam int RAD_LSB = 6;
  localparam int XDA_LSB = 13;
  localparam int WAD_LSB = 15;
  localparam int WIDTH_LSB = 22;
  localparam int HOLD_LSB = 30;
  localparam int SEL_LSB = 2;

  // write masks: unused bits are held at zero
  localparam logic [31:0] RANGE_MASK = 32'h0ffffff0;
  localparam logic [31:0] BASE_MASK = 32'h0ffffff1;
  localparam logic [31:0] DESC_MASK = 32'hffffffff;
  localparam logic [31:0] SEL_MASK = 32'h0ffffffd;

  // ----------------------------------------------------------------
  // reset values (the isa card setup)
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_MEM_RANGE = 32'h0f000000;
  localparam logic [31:0] RST_IO_RANGE = 32'h0f000000;
  localparam logic [31:0] RST_MEM_BASE = 32'h02000001;
  localparam logic [31:0] RST_IO_BASE = 32'h03000001;
  localparam logic [31:0] RST_MEM_DESC = 32'h40408042;
  localparam logic [31:0] RST_IO_DESC = 32'h40008042;
  localparam logic [31:0] RST_MEM_SEL = 32'h02800001;
  localparam logic [31:0] RST_IO_SEL = 32'h03000401;

  // ----------------------------------------------------------------
  // axi answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] mem_range;
    logic [31:0] io_range;
    logic [31:0] mem_base;
    logic [31:0] io_base;
    logic [31:0] mem_desc;
    logic [31:0] io_desc;
    logic [31:0] mem_sel;
    logic [31:0] io_sel;
  } config_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [27:0] addr;
  } local_req_s;

endpackage

// ---- rtl/isa_local_space_config.sv ----
/*
  isa local space configuration: axi4-lite register file holding the two
  local space setups and their chip selects, driving two space sequencers.
  assumes one 40 mhz clock; the ready input arrives from outside and is
  synchronised here.

  // What this block does
  // - range field decodes address lines 27 to 24
  // - both spaces memory mapped, location anywhere
  // - prefetch support bit stays cleared
  // - base bit 0 enables space decoding
  // - remap bases 2000000h memory, 3000000h io
  // - ready enable: external ready ends cycles
  // - one address-to-data wait, reads and writes
  // - data-to-address wait zero, ready governs it
  // - memory space uses 16-bit local bus
  // - io space uses 8-bit local bus
  // - little endian, lower data path used
  // - writes held one extra wait state
  // - select base bit 0 enables chip select
  // - select bases 2800000h and 3000400h
*/
`timescale 1ns/1ps
module isa_local_space_config
  import isa_space_pkg::*;
(
  input wire logic aclk, // 40 mhz clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic [5:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [5:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic req_valid, // local request strobe
  input wire logic req_write, // local request is a write
  input wire logic [27:0] req_addr, // local request address
  input wire logic local_ready_input_low, // ready from conversion logic, low
  output logic memory_select_low, // memory chip select, low
  output logic io_select_low, // io chip select, low
  output logic cycle_done, // one-cycle end of a local cycle
  output logic [1:0] bus_width, // width code of running cycle
  output logic big_lane // big-endian byte lane of running cycle
);

  typedef struct packed {
    config_s cfg;
    logic aw_held;
    logic [5:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic ready_meta;
    logic ready_sync;
    logic mem_sel_low;
    logic io_sel_low;
    logic done;
    logic [1:0] width;
    logic lane;
  } state_s;

  state_s state_reg;
  state_s state_next;
  local_req_s req;
  logic mem_hit;
  logic io_hit;
  logic mem_busy;
  logic io_busy;
  logic mem_done;
  logic io_done;
  logic mem_sel;
  logic io_sel;
  local_req_s io_req;

  // ----------------------------------------------------------------
  // local request routing
  // ----------------------------------------------------------------
  // one cycle at a time: a new request is ignored while either space is busy
  assign req = '{valid: req_valid && !mem_busy && !io_busy, write: req_write, addr: req_addr};
  // memory space wins when both decode the same address
  assign io_req = '{valid: req.valid && !mem_hit, write: req.write, addr: req.addr};

  space_cycle mem_space (
    .aclk(aclk),
    .aresetn(aresetn),
    .range_cfg(state_reg.cfg.mem_range),
    .base_cfg(state_reg.cfg.mem_base),
    .desc_cfg(state_reg.cfg.mem_desc),
    .sel_cfg(state_reg.cfg.mem_sel),
    .req(req),
    .ready_sync(state_reg.ready_sync),
    .hit(mem_hit),
    .busy(mem_busy),
    .done(mem_done),
    .select_low(mem_sel)
  );

  space_cycle io_space (
    .aclk(aclk),
    .aresetn(aresetn),
    .range_cfg(state_reg.cfg.io_range),
    .base_cfg(state_reg.cfg.io_base),
    .desc_cfg(state_reg.cfg.io_desc),
    .sel_cfg(state_reg.cfg.io_sel),
    .req(io_req),
    .ready_sync(state_reg.ready_sync),
    .hit(io_hit),
    .busy(io_busy),
    .done(io_done),
    .select_low(io_sel)
  );

  // ----------------------------------------------------------------
  // register write merge
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] result;
    result = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        result[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    // unused bits never hold a one
    merge = result & mask;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // ready pin crosses in through two flops; only the second is read
    state_next.ready_meta = ~local_ready_input_low;
    state_next.ready_sync = state_reg.ready_meta;
    state_next.done = mem_done || io_done;
    state_next.mem_sel_low = mem_sel;
    state_next.io_sel_low = io_sel;
    // width and lane of the space that takes the request
    if (mem_hit) begin
      state_next.width = state_reg.cfg.mem_desc[WIDTH_LSB +: 2];
      state_next.lane = state_reg.cfg.mem_desc[25];
    end else if (io_hit) begin
      state_next.width = state_reg.cfg.io_desc[WIDTH_LSB +: 2];
      state_next.lane = state_reg.cfg.io_desc[25];
    end

    // address and data are caught in either order
    if (s_axi_awvalid && !state_reg.aw_held) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_held) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    // write lands once both halves are held and no response is pending
    if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      case ({state_reg.aw_addr[5:2], 2'h0})
        OFF_MEM_RANGE: state_next.cfg.mem_range = merge(state_reg.cfg.mem_range, state_reg.w_data,
                                                        state_reg.w_strb, RANGE_MASK);
        OFF_IO_RANGE: state_next.cfg.io_range = merge(state_reg.cfg.io_range, state_reg.w_data,
                                                      state_reg.w_strb, RANGE_MASK);
        OFF_MEM_BASE: state_next.cfg.mem_base = merge(state_reg.cfg.mem_base, state_reg.w_data,
                                                      state_reg.w_strb, BASE_MASK);
        OFF_IO_BASE: state_next.cfg.io_base = merge(state_reg.cfg.io_base, state_reg.w_data,
                                                    state_reg.w_strb, BASE_MASK);
        OFF_MEM_DESC: state_next.cfg.mem_desc = merge(state_reg.cfg.mem_desc, state_reg.w_data,
                                                      state_reg.w_strb, DESC_MASK);
        OFF_IO_DESC: state_next.cfg.io_desc = merge(state_reg.cfg.io_desc, state_reg.w_data,
                                                    state_reg.w_strb, DESC_MASK);
        OFF_MEM_SEL: state_next.cfg.mem_sel = merge(state_reg.cfg.mem_sel, state_reg.w_data,
                                                    state_reg.w_strb, SEL_MASK);
        OFF_IO_SEL: state_next.cfg.io_sel = merge(state_reg.cfg.io_sel, state_reg.w_data,
                                                  state_reg.w_strb, SEL_MASK);
        OFF_STATUS: state_next.bresp = RESP_OKAY; // read-only, write ignored
        default: state_next.bresp = RESP_SLVERR;
      endcase
    end

    // reads: one outstanding, answered the cycle after the address is taken
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !state_reg.rvalid) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      case ({s_axi_araddr[5:2], 2'h0})
        OFF_MEM_RANGE: state_next.rdata = state_reg.cfg.mem_range;
        OFF_IO_RANGE: state_next.rdata = state_reg.cfg.io_range;
        OFF_MEM_BASE: state_next.rdata = state_reg.cfg.mem_base;
        OFF_IO_BASE: state_next.rdata = state_reg.cfg.io_base;
        OFF_MEM_DESC: state_next.rdata = state_reg.cfg.mem_desc;
        OFF_IO_DESC: state_next.rdata = state_reg.cfg.io_desc;
        OFF_MEM_SEL: state_next.rdata = state_reg.cfg.mem_sel;
        OFF_IO_SEL: state_next.rdata = state_reg.cfg.io_sel;
        // live state of both sequencers and the synchronised ready
        OFF_STATUS: state_next.rdata = {27'h0, state_reg.ready_sync, ~io_sel, ~mem_sel, io_busy, mem_busy};
        default: begin
          state_next.rdata = 32'h0;
          state_next.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset loads the isa card setup so the slot works before software runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.cfg <= '{RST_MEM_RANGE, RST_IO_RANGE, RST_MEM_BASE, RST_IO_BASE,
                         RST_MEM_DESC, RST_IO_DESC, RST_MEM_SEL, RST_IO_SEL};
      state_reg.mem_sel_low <= 1'b1;
      state_reg.io_sel_low <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign s_axi_awready = !state_reg.aw_held;
  assign s_axi_wready = !state_reg.w_held;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rdata = state_reg.rdata;
  assign memory_select_low = state_reg.mem_sel_low;
  assign io_select_low = state_reg.io_sel_low;
  assign cycle_done = state_reg.done;
  assign bus_width = state_reg.width;
  assign big_lane = state_reg.lane;

endmodule

// ---- rtl/space_cycle.sv ----
/*
  one local address space: decode, chip select and cycle timing for a
  single space. assumes its configuration word set comes from the register
  file and its ready input is already synchronised.
*/
`timescale 1ns/1ps
module space_cycle
  import isa_space_pkg::*;
(
  input wire logic aclk, // 40 mhz clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic [31:0] range_cfg, // space range word
  input wire logic [31:0] base_cfg, // space base word
  input wire logic [31:0] desc_cfg, // region descriptor word
  input wire logic [31:0] sel_cfg, // chip select base word
  input wire local_req_s req, // request from the local side
  input wire logic ready_sync, // synchronised ready input
  output logic hit, // request lands in this space
  output logic busy, // cycle under way
  output logic done, // one-cycle end of cycle
  output logic select_low // chip select, low active
);

  typedef enum logic [1:0] {IDLE, ADDR, DATA, HOLD} phase_e;
  typedef struct packed {
    phase_e phase;
    logic [4:0] count;
    logic write;
    logic sel;
    logic done;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic [27:0] rmask;
  logic [25:0] smask;
  logic sel_hit;
  logic ready_mode;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // range bits set mark the address lines that take part in decode
  assign rmask = {range_cfg[27:RANGE_LSB], 4'h0};
  assign hit = req.valid && base_cfg[ENABLE_BIT] &&
               ((req.addr & rmask) == (base_cfg[27:0] & rmask & 28'hffffff0));
  // chip select matches on the same range, from its own base
  assign smask = rmask[27:2];
  assign sel_hit = sel_cfg[ENABLE_BIT] &&
                   ((req.addr[27:2] & smask) == (sel_cfg[27:SEL_LSB] & smask));
  assign ready_mode = desc_cfg[READY_EN_BIT];

  // ----------------------------------------------------------------
  // cycle sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    case (state_reg.phase)
      IDLE: begin
        if (hit) begin
          state_next.phase = ADDR;
          state_next.write = req.write;
          state_next.sel = sel_hit;
          // address-to-data waits from the descriptor
          state_next.count = req.write ? desc_cfg[WAD_LSB +: 5] : desc_cfg[RAD_LSB +: 5];
        end
      end
      ADDR: begin
        if (state_reg.count == 5'h0) begin
          state_next.phase = DATA;
          state_next.count = {3'h0, desc_cfg[XDA_LSB +: 2]};
        end else begin
          state_next.count = state_reg.count - 5'h1;
        end
      end
      DATA: begin
        // external ready ends the cycle when enabled, else the count does
        if (ready_mode ? ready_sync : (state_reg.count == 5'h0)) begin
          if (state_reg.write && desc_cfg[HOLD_LSB +: 2] != 2'h0) begin
            state_next.phase = HOLD;
            state_next.count = {3'h0, desc_cfg[HOLD_LSB +: 2]} - 5'h1;
          end else begin
            state_next.phase = IDLE;
            state_next.sel = 1'b0;
            state_next.done = 1'b1;
          end
        end else if (state_reg.count != 5'h0) begin
          state_next.count = state_reg.count - 5'h1;
        end
      end
      HOLD: begin
        if (state_reg.count == 5'h0) begin
          state_next.phase = IDLE;
          state_next.sel = 1'b0;
          state_next.done = 1'b1;
        end else begin
          state_next.count = state_reg.count - 5'h1;
        end
      end
      default: begin
        state_next.phase = IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '{phase: IDLE, count: 5'h0, write: 1'b0, sel: 1'b0, done: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = (state_reg.phase != IDLE);
  assign done = state_reg.done;
  assign select_low = ~state_reg.sel;

endmodule

// ---- testbench/isa_card_model.sv ----
/*
  isa card behind the conversion logic: answers each selected cycle on
  the ready pin. assumes the bench clock and a delay set per cycle.
*/
`timescale 1ns/1ps
module isa_card_model (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic memory_select_low, // memory chip select, low
  input wire logic io_select_low, // io chip select, low
  input wire logic [3:0] delay, // card wait before ready
  output logic local_ready_input_low // ready toward the bridge, low
);
  logic [3:0] wait_reg;
  // ------------------------------------------------------------
  // ready after the card's wait; io cycles one slower
  // ------------------------------------------------------------
  // only slave cycles are answered: no refresh, dma or splitting
  // card raises no interrupts: its requests would be ored onto one local input
  // and its channel-check error kept apart on the second one
  always_ff @(posedge aclk) begin
    if (!aresetn || (memory_select_low && io_select_low)) begin
      wait_reg <= 4'h0;
      local_ready_input_low <= 1'b1; // pin idles high on its pull-up
    end else if (wait_reg == delay + {3'h0, !io_select_low}) begin
      local_ready_input_low <= 1'b0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

// ---- testbench/isa_local_space_config_monitor.sv ----
/*
  checker for the isa space block: axi answer rules, chip select and
  cycle-end relations. assumes it is bound to the top module's ports.
*/
`timescale 1ns/1ps
module isa_local_space_config_monitor (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic s_axi_awready, // watched
  input wire logic s_axi_wready, // watched
  input wire logic [1:0] s_axi_bresp, // watched
  input wire logic s_axi_bvalid, // watched
  input wire logic s_axi_bready, // watched
  input wire logic s_axi_arready, // watched
  input wire logic [31:0] s_axi_rdata, // watched
  input wire logic [1:0] s_axi_rresp, // watched
  input wire logic s_axi_rvalid, // watched
  input wire logic s_axi_rready, // watched
  input wire logic local_ready_input_low, // watched
  input wire logic memory_select_low, // watched
  input wire logic io_select_low, // watched
  input wire logic cycle_done, // watched
  input wire logic [1:0] bus_width, // watched
  input wire logic big_lane // watched
);
  logic [3:0] since_rdy;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // cycles since the card last drove ready, saturating
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_rdy <= 4'hf;
    end else if (!local_ready_input_low) begin
      since_rdy <= 4'h0;
    end else if (since_rdy != 4'hf) begin
      since_rdy <= since_rdy + 4'h1;
    end
  end
  AST_B_AFTER_BOTH: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
    else $error("write answer before both halves were held");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata}))
    else $error("read answer dropped early");
  AST_AR_BLOCK: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready while answer pending");
  AST_DONE_PULSE: assert property (cycle_done |=> !cycle_done)
    else $error("cycle end longer than one cycle");
  AST_SELECT_EXCL: assert property (memory_select_low || io_select_low)
    else $error("both chip selects low");
  AST_MEM_WIDTH: assert property (!memory_select_low |-> bus_width == 2'h1 && !big_lane)
    else $error("memory cycle not 16 bit little endian");
  AST_IO_WIDTH: assert property (!io_select_low |-> bus_width == 2'h0 && !big_lane)
    else $error("io cycle not 8 bit little endian");
  AST_READY_ENDS: assert property (cycle_done |-> since_rdy < 4'h8)
    else $error("cycle ended without the ready input");
  COV_MEM: cover property (!memory_select_low);
  COV_IO: cover property (!io_select_low);
  COV_SLOW_B: cover property (s_axi_bvalid && !s_axi_bready);
  COV_DONE: cover property (cycle_done);
endmodule
bind isa_local_space_config isa_local_space_config_monitor i_monitor (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .local_ready_input_low, .memory_select_low, .io_select_low, .cycle_done,
  .bus_width, .big_lane);

// ---- testbench/isa_local_space_config_test.sv ----
/*
  bench for the isa space block: axi register tasks, local cycle driver
  and a result watcher. assumes the card model answers on the ready pin.
*/
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, e, s); end end
module isa_local_space_config_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, bus_width;
  logic req_valid = '0, req_write = '0, local_ready_input_low, memory_select_low, io_select_low;
  logic [27:0] req_addr = '0;
  logic cycle_done, big_lane;
  logic [3:0] delay = '0;
  int n_mismatch = 0, checks = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [2:0] lq[$];
  logic [31:0] rst_tab [8] = '{32'h0f000000, 32'h0f000000, 32'h02000001, 32'h03000001,
    32'h40408042, 32'h40008042, 32'h02800001, 32'h03000401};
  isa_local_space_config i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid,
    .req_write, .req_addr, .local_ready_input_low, .memory_select_low, .io_select_low, .cycle_done,
    .bus_width, .big_lane);
  isa_card_model i_card (.aclk, .aresetn, .memory_select_low, .io_select_low, .delay, .local_ready_input_low);
  initial forever #12.5 aclk = ~aclk;
  // ------------------------------------------------------------
  // verdict and hang cut-off
  // ------------------------------------------------------------
  task automatic results();
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tmo();
    n_mismatch++;
    results();
  endtask
  // ------------------------------------------------------------
  // axi master tasks; ready raised late to stretch the answer
  // ------------------------------------------------------------
  task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (i == 50) tmo();
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    if (i == 50) tmo();
  endtask
  // one local request; ex is {hit, width}, n the edges until its end
  task automatic lcyc(input logic [27:0] a, input logic w, input logic [3:0] d, input logic [2:0] ex, output int n);
    int i;
    if (ex[2]) lq.push_back({ex[1:0], 1'b0});
    delay <= d;
    req_addr <= a;
    req_write <= w;
    req_valid <= 1'b1;
    @(posedge aclk);
    req_valid <= 1'b0;
    for (i = 0; i < 60 && !cycle_done; i++) @(posedge aclk);
    n = i;
    if (ex[2] && i == 60) tmo();
    if (!ex[2]) `CHK("no_cycle", 60, i)
    repeat (4) @(posedge aclk);
  endtask
  // watcher: oldest note against each result as it appears
  always @(posedge aclk) begin
    logic [33:0] er;
    logic [2:0] el;
    logic [1:0] eb;
    if (s_axi_rvalid && s_axi_rready) begin
      er = rq.size() ? rq.pop_front() : 'x;
      `CHK("read", er, {s_axi_rresp, s_axi_rdata})
    end
    if (s_axi_bvalid && s_axi_bready) begin
      eb = bq.size() ? bq.pop_front() : 'x;
      `CHK("bresp", eb, s_axi_bresp)
    end
    if (cycle_done) begin
      el = lq.size() ? lq.pop_front() : 'x;
      `CHK("width", el, {bus_width, big_lane})
    end
  end
  initial begin
    int n0, n1, n2, k;
    logic [3:0] d;
    logic [27:0] a;
    void'($urandom(58710));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 8; k++) rd(6'(k * 4), rst_tab[k], 2'h0);
    rd(6'h24, 32'h0, 2'h2);
    wr(6'h28, 32'h1, 2'h2);
    wr(6'h20, 32'h1, 2'h0);
    wr(6'h00, 32'hffffffff, 2'h0);
    rd(6'h00, 32'h0ffffff0, 2'h0);
    // only the strobed byte lane may change
    s_axi_wstrb <= 4'h1;
    wr(6'h00, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(6'h00, 32'h0fffff00, 2'h0);
    wr(6'h00, 32'h0f000000, 2'h0);
    for (k = 0; k < 2; k++) begin
      d = 4'(2 + $urandom % 3);
      a = {k ? 4'h3 : 4'h2, 24'($urandom)};
      lcyc(a, 1'b0, d, {1'b1, 2'(1 - k)}, n0);
      lcyc(a, 1'b0, d + 4'h3, {1'b1, 2'(1 - k)}, n1);
      lcyc(a, 1'b1, d, {1'b1, 2'(1 - k)}, n2);
      `CHK("ready_wait", n0 + 3, n1)
      `CHK("write_hold", n0 + 1, n2)
      // two sync flops, one address wait, card wait (io card one slower)
      `CHK("addr_wait", 7 + k + int'(d), n0)
    end
    a = {4'h1, 24'($urandom)};
    lcyc(a, 1'b0, 4'h2, 3'h0, n0);
    wr(6'h08, 32'h02000000, 2'h0);
    a[27:24] = 4'h2;
    lcyc(a, 1'b0, 4'h2, 3'h0, n0);
    wr(6'h08, 32'h02000001, 2'h0);
    lcyc(a, 1'b1, 4'h2, 3'h5, n0);
    results();
  end
endmodule
